/* File: hw/eeprom_pkg.sv */
// Shared constants and types for the serial EEPROM command port and its controller.
package eeprom_pkg;

    // =====================================================================
    // Clock and timing
    // =====================================================================
    localparam int CLK_PERIOD_NS   = 5;
    localparam int TW_MS           = 10;
    localparam int TW_CYCLES       = TW_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SCK_HALF_NS     = 500;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_GAP_NS       = 250;
    localparam int CS_GAP_CYCLES   = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POLL_NS         = 500;
    localparam int POLL_CYCLES     = (POLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W      = 24;
    localparam int DIV_W           = 8;

    // =====================================================================
    // Array geometry and frame lengths
    // =====================================================================
    localparam int       MEM_BYTES = 512;
    localparam logic [4:0] HDR_X16 = 5'h0b;
    localparam logic [4:0] HDR_X8  = 5'h0c;
    localparam logic [4:0] FULL_X16 = 5'h1b;
    localparam logic [4:0] FULL_X8  = 5'h14;

    // =====================================================================
    // Opcodes and extended selectors
    // =====================================================================
    localparam logic [1:0] OP_EXT        = 2'h0;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_ERASE      = 2'h3;
    localparam logic [1:0] EXT_LOCK      = 2'h0;
    localparam logic [1:0] EXT_FILL_ALL  = 2'h1;
    localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
    localparam logic [1:0] EXT_UNLOCK    = 2'h3;

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic [1:0] {PK_WRITE, PK_ERASE, PK_CLEAR_ALL, PK_FILL_ALL} prog_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_READ, ST_BUSY} dev_state_t;
    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP, H_POLL} host_state_t;

endpackage

/* File: hw/eeprom_link_if.sv */
// Four-wire serial link between the EEPROM controller and the EEPROM command port.
interface eeprom_link_if;

    // =====================================================================
    // Link wires
    // =====================================================================
    logic cs;
    logic sck;
    logic sdi;
    logic sdo;

    modport dev  (input cs, input sck, input sdi, output sdo);
    modport host (output cs, output sck, output sdi, input sdo);

endinterface

/* File: hw/eeprom_device.sv */
// Serial EEPROM command port: instruction decoder, read streamer and self-timed programmer.
//
// Summary of operation
// - Width pin high selects words, low bytes.
// - Reset clears sequencer and locks programming.
// - Start bit, opcode, address, most significant first.
// - Opcode 10 loads addressed data for output.
// - Read sends dummy zero, then data bits.
// - Read data changes only on clock rise.
// - Held select streams next locations, no dummy.
// - Opcode 01 takes address then data bits.
// - Host drops select before next rise after data.
// - Single write erases location before programming.
// - Opcode 11 erases addressed location on deselect.
// - Opcode 00 subcodes unlock, lock, clear, fill.
// - Unlock persists until lock or reset.
// - Host should lock after every write.
// - Reads ignore the programming lock.
// - Busy drives output low, ignores input.
// - Finished cycle drives output high while selected.
// - Programming timer runs without the serial clock.
// - Clear-all sets every bit, dummy address.
// - Fill-all programs without erasing first.
// - Ready level held until start bit or deselect.
// - Programming needs exact clock pulse count.
module eeprom_device
    import eeprom_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = TW_CYCLES
) (
    input  wire logic  clk_i,
    input  wire logic  arst_n_i,
    input  wire logic  org_i,
    eeprom_link_if.dev link,
    output logic       busy_o,
    output logic       unlocked_o
);

    // =====================================================================
    // State
    // =====================================================================
    dev_state_t              state_q;
    prog_kind_t              pkind_q;
    logic                    sck_q;
    logic                    cs_q;
    logic [4:0]              cnt_q;
    logic [25:0]             sr_q;
    logic [1:0]              op_q;
    logic [8:0]              addr_q;
    logic [3:0]              bitc_q;
    logic [15:0]             out_q;
    logic [15:0]             pdata_q;
    logic [PROG_CNT_W-1:0]   timer_q;
    logic                    sdo_q;
    logic                    sdo_d;
    logic                    wel_q;
    logic                    rdy_q;
    logic                    busy_q;
    logic [7:0]              mem_q [MEM_BYTES];

    // =====================================================================
    // Decoding
    // =====================================================================
    wire             wide     = org_i;
    wire             rise     = link.sck & ~sck_q & link.cs;
    wire             cs_fall  = cs_q & ~link.cs;
    wire [4:0]       hdr      = wide ? HDR_X16 : HDR_X8;
    wire [4:0]       full     = wide ? FULL_X16 : FULL_X8;
    wire [4:0]       cnt_nx   = (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
    wire [25:0]      sr_nx    = {sr_q[24:0], link.sdi};
    wire [1:0]       hdr_op   = wide ? sr_nx[9:8] : sr_nx[10:9];
    wire [8:0]       hdr_addr = wide ? {1'b0, sr_nx[7:0]} : sr_nx[8:0];
    wire             at_hdr   = (state_q == ST_CMD) && rise && (cnt_nx == hdr);
    wire [8:0]       addr_inc = wide ? {1'b0, addr_q[7:0] + 8'h01} : addr_q + 9'h001;
    wire [8:0]       rd_addr  = (state_q == ST_READ) ? addr_inc : hdr_addr;
    wire [15:0]      rd_word  = wide ? {mem_q[{rd_addr[7:0], 1'b0}], mem_q[{rd_addr[7:0], 1'b1}]}
                                     : {8'h00, mem_q[rd_addr]};
    wire             last_bit = bitc_q == (wide ? 4'hf : 4'h7);
    wire             out_msb  = wide ? out_q[15] : out_q[7];
    wire [1:0]       ext_sel  = wide ? addr_q[7:6] : addr_q[8:7];
    wire             got_hdr  = cnt_q >= hdr;
    wire             is_ext   = op_q == OP_EXT;

    // Programming instructions and their kind.
    wire             is_prog  = (op_q == OP_WRITE) || (op_q == OP_ERASE) ||
                                (is_ext && (ext_sel == EXT_CLEAR_ALL || ext_sel == EXT_FILL_ALL));
    wire prog_kind_t pk_d     = (op_q == OP_WRITE) ? PK_WRITE :
                                (op_q == OP_ERASE) ? PK_ERASE :
                                (ext_sel == EXT_CLEAR_ALL) ? PK_CLEAR_ALL : PK_FILL_ALL;
    wire             need_dat = (pk_d == PK_WRITE) || (pk_d == PK_FILL_ALL);
    wire             cnt_ok   = cnt_q == (need_dat ? full : hdr);
    wire             in_cmd_e = cs_fall && (state_q == ST_CMD) && got_hdr;
    wire             start_pg = in_cmd_e && is_prog && cnt_ok && wel_q;
    wire             refuse   = in_cmd_e && is_prog && !start_pg;
    wire             commit   = (state_q == ST_BUSY) && (timer_q == '0);

    // =====================================================================
    // Instruction sequencer
    // =====================================================================
    // Edge detectors for the serial clock and the select line.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_q <= 1'b0;
            cs_q  <= 1'b0;
        end else begin
            sck_q <= link.sck;
            cs_q  <= link.cs;
        end
    end

    // Main sequencer; the programming timer runs on the system clock alone.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
            sr_q    <= '0;
            op_q    <= OP_READ;
            addr_q  <= 9'h000;
            out_q   <= 16'h0000;
            bitc_q  <= 4'h0;
            pkind_q <= PK_WRITE;
            pdata_q <= 16'h0000;
            timer_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (rise && link.sdi) begin
                        state_q <= ST_CMD;
                        cnt_q   <= 5'h01;
                        sr_q    <= '0;
                    end
                end
                ST_CMD: begin
                    if (!link.cs) begin
                        state_q <= start_pg ? ST_BUSY : ST_IDLE;
                        pkind_q <= pk_d;
                        pdata_q <= wide ? sr_q[15:0] : {8'h00, sr_q[7:0]};
                        timer_q <= PROG_CNT_W'(PROG_CYCLES - 1);
                    end else if (rise) begin
                        cnt_q <= cnt_nx;
                        sr_q  <= sr_nx;
                        if (cnt_nx == hdr) begin
                            op_q   <= hdr_op;
                            addr_q <= hdr_addr;
                            if (hdr_op == OP_READ) begin
                                state_q <= ST_READ;
                                out_q   <= rd_word;
                                bitc_q  <= 4'h0;
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (!link.cs) begin
                        state_q <= ST_IDLE;
                    end else if (rise) begin
                        bitc_q <= last_bit ? 4'h0 : bitc_q + 4'h1;
                        out_q  <= last_bit ? rd_word : {out_q[14:0], 1'b0};
                        if (last_bit) begin
                            addr_q <= addr_inc;
                        end
                    end
                end
                ST_BUSY: begin
                    timer_q <= timer_q - PROG_CNT_W'(1);
                    if (commit) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Programming lock, ready flag and busy status; a set of ready wins over its clear.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wel_q  <= 1'b0;
            rdy_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (in_cmd_e && is_ext && ext_sel == EXT_UNLOCK) begin
                wel_q <= 1'b1;
            end else if (in_cmd_e && is_ext && ext_sel == EXT_LOCK) begin
                wel_q <= 1'b0;
            end
            if (commit || refuse) begin
                rdy_q <= 1'b1;
            end else if (cs_fall || (state_q == ST_IDLE && rise && link.sdi)) begin
                rdy_q <= 1'b0;
            end
            busy_q <= start_pg ? 1'b1 : (commit ? 1'b0 : busy_q);
        end
    end

    // =====================================================================
    // Serial data out
    // =====================================================================
    // Output level: busy low, ready high, read data on clock rises only.
    always_comb begin
        sdo_d = sdo_q;
        if (!link.cs) begin
            sdo_d = 1'b0;
        end else if (state_q == ST_BUSY) begin
            sdo_d = 1'b0;
        end else if (rdy_q) begin
            sdo_d = 1'b1;
        end else if (at_hdr && hdr_op == OP_READ) begin
            sdo_d = 1'b0;
        end else if (state_q == ST_READ && rise) begin
            sdo_d = out_msb;
        end else if (state_q != ST_READ) begin
            sdo_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= sdo_d;
        end
    end

    assign link.sdo   = sdo_q;
    assign busy_o     = busy_q;
    assign unlocked_o = wel_q;

    // =====================================================================
    // Array; content is nonvolatile and is not touched by reset
    // =====================================================================
    for (genvar i = 0; i < MEM_BYTES; i++) begin : g_byte
        localparam logic [8:0] IDX = 9'(i);
        logic       hit;
        logic [7:0] src;
        logic [7:0] nval;

        // Location match, source byte and new value for this cell.
        assign hit  = wide ? (IDX[8:1] == addr_q[7:0]) : (IDX == addr_q);
        assign src  = (wide && !IDX[0]) ? pdata_q[15:8] : pdata_q[7:0];
        assign nval = (pkind_q == PK_WRITE)    ? src :
                      (pkind_q == PK_FILL_ALL) ? (mem_q[i] & src) :
                      8'hff;

        always_ff @(posedge clk_i) begin
            if (commit && (hit || pkind_q == PK_CLEAR_ALL || pkind_q == PK_FILL_ALL)) begin
                mem_q[i] <= nval;
            end
        end
    end

endmodule

/* File: hw/eeprom_host.sv */
// Serial bus master that drives the EEPROM link from single-command requests.
module eeprom_host
    import eeprom_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        org_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [1:0]  op_i,
    input  wire logic [8:0]  addr_i,
    input  wire logic [15:0] data_i,
    input  wire logic [7:0]  words_i,
    output logic             cmd_ready_o,
    output logic [15:0]      rd_data_o,
    output logic             rd_valid_o,
    output logic             done_o,
    eeprom_link_if.host      link
);

    // =====================================================================
    // State
    // =====================================================================
    host_state_t       state_q;
    logic [DIV_W-1:0]  div_q;
    logic [26:0]       sh_q;
    logic [11:0]       pcnt_q;
    logic [11:0]       total_q;
    logic [3:0]        bitc_q;
    logic [15:0]       rx_q;
    logic              wide_q;
    logic              rd_q;
    logic              poll_q;
    logic              cs_q;
    logic              sck_q;
    logic              sdi_q;
    logic              ready_q;
    logic [15:0]       rd_data_q;
    logic              rd_valid_q;
    logic              done_q;

    // =====================================================================
    // Request decoding
    // =====================================================================
    wire              tick    = div_q == '0;
    wire [1:0]        sel_i   = org_i ? addr_i[7:6] : addr_i[8:7];
    wire [4:0]        hdr_i   = org_i ? HDR_X16 : HDR_X8;
    wire [7:0]        wn      = (words_i == 8'h00) ? 8'h01 : words_i;
    wire              is_rd   = op_i == OP_READ;
    wire              has_dat = (op_i == OP_WRITE) || (op_i == OP_EXT && sel_i == EXT_FILL_ALL);
    wire              pollreq = (op_i == OP_WRITE) || (op_i == OP_ERASE) ||
                                (op_i == OP_EXT && (sel_i == EXT_FILL_ALL || sel_i == EXT_CLEAR_ALL));
    wire [11:0]       rd_len  = org_i ? {words_i == 8'h00 ? 8'h01 : wn, 4'h0} : {1'b0, wn, 3'h0};
    wire [11:0]       dat_len = has_dat ? (org_i ? 12'h010 : 12'h008) : 12'h000;
    wire [11:0]       tot_i   = {7'h00, hdr_i} + (is_rd ? rd_len : dat_len);
    wire [4:0]        hdr_q   = wide_q ? HDR_X16 : HDR_X8;
    wire              capture = rd_q && (pcnt_q > {7'h00, hdr_q});
    wire              last_rx = bitc_q == (wide_q ? 4'hf : 4'h7);
    wire [15:0]       rx_word = wide_q ? {rx_q[14:0], link.sdo} : {8'h00, rx_q[6:0], link.sdo};

    // =====================================================================
    // Sequencer
    // =====================================================================
    // Frames a command, clocks it out, collects read data and polls for ready.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q    <= H_IDLE;
            div_q      <= '0;
            sh_q       <= '0;
            pcnt_q     <= 12'h000;
            total_q    <= 12'h000;
            bitc_q     <= 4'h0;
            rx_q       <= 16'h0000;
            wide_q     <= 1'b1;
            rd_q       <= 1'b0;
            poll_q     <= 1'b0;
            cs_q       <= 1'b0;
            sck_q      <= 1'b0;
            sdi_q      <= 1'b0;
            ready_q    <= 1'b0;
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
            done_q     <= 1'b0;
        end else begin
            rd_valid_q <= 1'b0;
            done_q     <= 1'b0;
            div_q      <= tick ? DIV_W'(SCK_HALF_CYCLES - 1) : div_q - DIV_W'(1);
            case (state_q)
                H_IDLE: begin
                    ready_q <= 1'b1;
                    if (cmd_valid_i && ready_q) begin
                        ready_q <= 1'b0;
                        state_q <= H_SHIFT;
                        cs_q    <= 1'b1;
                        sck_q   <= 1'b0;
                        sdi_q   <= 1'b1;
                        div_q   <= DIV_W'(SCK_HALF_CYCLES - 1);
                        sh_q    <= org_i ? {1'b1, op_i, addr_i[7:0], data_i}
                                         : {1'b1, op_i, addr_i, data_i[7:0], 7'h00};
                        pcnt_q  <= 12'h000;
                        total_q <= tot_i;
                        bitc_q  <= 4'h0;
                        wide_q  <= org_i;
                        rd_q    <= is_rd;
                        poll_q  <= pollreq;
                    end
                end
                H_SHIFT: begin
                    if (tick && !sck_q) begin
                        sck_q  <= 1'b1;
                        pcnt_q <= pcnt_q + 12'h001;
                    end else if (tick) begin
                        sck_q <= 1'b0;
                        sh_q  <= {sh_q[25:0], 1'b0};
                        sdi_q <= sh_q[25];
                        if (capture) begin
                            rx_q   <= {rx_q[14:0], link.sdo};
                            bitc_q <= last_rx ? 4'h0 : bitc_q + 4'h1;
                            if (last_rx) begin
                                rd_data_q  <= rx_word;
                                rd_valid_q <= 1'b1;
                            end
                        end
                        if (pcnt_q == total_q) begin
                            cs_q    <= 1'b0;
                            sdi_q   <= 1'b0;
                            state_q <= H_GAP;
                            div_q   <= DIV_W'(CS_GAP_CYCLES - 1);
                        end
                    end
                end
                H_GAP: begin
                    if (tick && poll_q) begin
                        cs_q    <= 1'b1;
                        state_q <= H_POLL;
                        div_q   <= DIV_W'(POLL_CYCLES - 1);
                    end else if (tick) begin
                        done_q  <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                H_POLL: begin
                    if (tick && link.sdo) begin
                        cs_q    <= 1'b0;
                        poll_q  <= 1'b0;
                        state_q <= H_GAP;
                        div_q   <= DIV_W'(CS_GAP_CYCLES - 1);
                    end else if (tick) begin
                        div_q <= DIV_W'(POLL_CYCLES - 1);
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    assign link.cs     = cs_q;
    assign link.sck    = sck_q;
    assign link.sdi    = sdi_q;
    assign cmd_ready_o = ready_q;
    assign rd_data_o   = rd_data_q;
    assign rd_valid_o  = rd_valid_q;
    assign done_o      = done_q;

endmodule

/* File: tb/eeprom_link_monitor.sv */
// Link checker for the EEPROM controller and command port.
module eeprom_link_monitor (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic cs_i,
    input wire logic sck_i,
    input wire logic sdo_i,
    input wire logic busy_i,
    input wire logic unlocked_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==============
    // Properties
    // ==============
    // Every check runs on the system clock and rests during reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    AST_SDO_IDLE: assert property ((!cs_i) [*2] |-> !sdo_i)
        else $error("sdo high while deselected.");
    AST_BUSY_LOW: assert property ((busy_i && cs_i) [*3] |-> !sdo_i)
        else $error("sdo high while busy.");
    AST_LOCK_GATE: assert property ($rose(busy_i) |-> $past(unlocked_i))
        else $error("Programming started while locked.");
    AST_START_DESEL: assert property ($rose(busy_i) |-> !cs_i && !$past(cs_i))
        else $error("Programming started while selected.");
    // The bench runs the programmer with 200 cycles, so busy ends exactly then.
    AST_PROG_TIME: assert property ($rose(busy_i) |=> busy_i [*8] ##191 busy_i ##1 !busy_i)
        else $error("Programming time wrong.");
    AST_READY: assert property ($fell(busy_i) ##1 cs_i [*3] |-> sdo_i)
        else $error("Ready level missing.");
    AST_CS_RISE: assert property ($rose(cs_i) |-> !sck_i)
        else $error("Select raised with clock high.");
    AST_SCK_SEL: assert property ($rose(sck_i) |-> cs_i)
        else $error("Clock rise while deselected.");
    // Main scenarios seen.
    COV_PROG: cover property ($rose(busy_i));
    COV_LOCK: cover property ($fell(unlocked_i));
    COV_POLL: cover property ($fell(busy_i) ##1 cs_i);
endmodule

/* File: tb/serial_eeprom_command_port_bench.sv */
// Self-checking bench joining the EEPROM controller to the command port.
module serial_eeprom_command_port_bench
    import eeprom_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, arst_n_i, org, cmd_valid, cmd_ready, rd_valid, done, busy, unlocked;
    logic [1:0]  op;
    logic [7:0]  words;
    logic [8:0]  addr, a;
    logic [15:0] wdata, rd_data, msk, d1, d2;
    logic [31:0] seed = 32'hf1b5;
    logic [15:0] exp_q[$];
    int          err_count = 0;
    int          check_count = 0;
    eeprom_link_if link ();
    eeprom_device #(.PROG_CYCLES(200)) i_eeprom_device (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .org_i(org), .link(link), .busy_o(busy), .unlocked_o(unlocked));
    eeprom_host i_eeprom_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .org_i(org),
        .cmd_valid_i(cmd_valid), .op_i(op), .addr_i(addr), .data_i(wdata), .words_i(words),
        .cmd_ready_o(cmd_ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .done_o(done),
        .link(link));
    eeprom_link_monitor i_eeprom_link_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .cs_i(link.cs), .sck_i(link.sck), .sdo_i(link.sdo), .busy_i(busy), .unlocked_i(unlocked));
    // ==============
    // Helpers
    // ==============
    // Xorshift source for addresses and data.
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // Places a subcode in the two leading address bits of the current format.
    function automatic logic [8:0] ext(input logic [1:0] s);
        return org ? {1'b0, s, 6'h00} : {s, 7'h00};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Waits a bounded time for ready, or for done, sampled high at a rising edge.
    task automatic wait_hi(input bit on_done);
        int n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((on_done ? done : cmd_ready) !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            err_count++;
            stop_test();
        end
    endtask
    // Hands one command to the controller and waits for its completion.
    task automatic cmd(input logic [1:0] o, input logic [8:0] ad, input logic [15:0] d,
                       input logic [7:0] n);
        wait_hi(1'b0);
        op <= o;
        addr <= ad;
        wdata <= d & msk;
        words <= n;
        cmd_valid <= 1'b1;
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        wait_hi(1'b1);
    endtask
    // ==============
    // Clock, watcher and sequence
    // ==============
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Each read word is compared with the oldest note.
    always @(posedge clk_i) begin
        if (rd_valid === 1'b1) check(rd_data & msk, exp_q.pop_front());
    end
    initial begin
        {arst_n_i, cmd_valid, op, addr, wdata, words} = '0;
        org = 1'b1;
        msk = 16'hffff;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        check(16'(unlocked), 16'h0000);
        for (int p = 0; p < 2; p++) begin
            org <= (p == 0);
            msk <= (p == 0) ? 16'hffff : 16'h00ff;
            @(posedge clk_i);
            a = 9'(rnd()) & ((p == 0) ? 9'h0ff : 9'h1ff);
            d1 = rnd() & msk;
            d2 = rnd() & msk & 16'hfffe;
            cmd(OP_EXT, ext(EXT_UNLOCK), 16'h0000, 8'h01);
            check(16'(unlocked), 16'h0001);
            cmd(OP_EXT, ext(EXT_CLEAR_ALL), 16'h0000, 8'h01);
            cmd(OP_WRITE, a, d1, 8'h01);
            exp_q.push_back(d1);
            exp_q.push_back(msk);
            cmd(OP_READ, a, 16'h0000, 8'h02);
            cmd(OP_EXT, ext(EXT_FILL_ALL), d2, 8'h01);
            cmd(OP_ERASE, a + 9'h001, 16'h0000, 8'h01);
            exp_q.push_back(d1 & d2);
            exp_q.push_back(msk);
            cmd(OP_READ, a, 16'h0000, 8'h02);
            cmd(OP_WRITE, a, ~d1, 8'h01);
            cmd(OP_EXT, ext(EXT_LOCK), 16'h0000, 8'h01);
            check(16'(unlocked), 16'h0000);
            cmd(OP_WRITE, a, d1, 8'h01);
            exp_q.push_back(~d1 & msk);
            cmd(OP_READ, a, 16'h0000, 8'h01);
            $display("format pass %0d ended", p);
        end
        check(16'(exp_q.size()), 16'h0000);
        stop_test();
    end
endmodule
